// file: dopc_pkg.sv
// shared constants for the demodulator output pin configuration block
package dopc_pkg;
    // ========================================
    // register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [7:0] OFS_OUT_EN    = 8'h00;
    localparam logic [7:0] OFS_TS_CFG    = 8'h01;
    localparam logic [7:0] OFS_LOCK_MODE = 8'h02;
    localparam logic [7:0] OFS_GAIN_CTRL = 8'h03;
    localparam logic [7:0] OFS_GAIN_LVL1 = 8'h04;
    localparam logic [7:0] OFS_GAIN_LVL2 = 8'h05;
    localparam logic [7:0] OFS_GAIN_LVL3 = 8'h06;
    localparam logic [7:0] OFS_XTAL_KHZ  = 8'h07;
    localparam logic [7:0] OFS_IF_KHZ    = 8'h08;
    localparam logic [7:0] OFS_CHAN      = 8'h09;
    localparam logic [7:0] OFS_START     = 8'h0A;
    localparam logic [7:0] OFS_STATUS    = 8'h0B;
    // ========================================
    // field positions
    localparam int BIT_STREAM_EN  = 0;
    localparam int BIT_MONITOR_EN = 1;
    localparam int BIT_MISC_EN    = 2;
    localparam int BIT_PARITY     = 0;
    localparam int BIT_GAP_GATE   = 1;
    localparam int POS_DEMOD_MODE = 0;
    localparam int POS_CORR_MODE  = 4;
    localparam int POS_GAIN_MODE  = 0;
    localparam int BIT_GAIN_NEG   = 2;
    localparam int BIT_MIRROR     = 0;
    localparam int POS_BW         = 2;
    // ========================================
    // encodings
    localparam logic [2:0] LOCK_PIN_INDICATOR_SEL = 3'h0;
    localparam logic [2:0] LOCK_PIN_FILTER8_SEL   = 3'h1;
    localparam logic [2:0] LOCK_PIN_FILTER7_SEL   = 3'h2;
    localparam logic [2:0] LOCK_PIN_FIXED_LOW     = 3'h3;
    localparam logic [2:0] LOCK_PIN_FIXED_HIGH    = 3'h4;
    localparam logic [1:0] GAIN_OFF  = 2'h0;
    localparam logic [1:0] GAIN_FAST = 2'h1;
    localparam logic [1:0] GAIN_SLOW = 2'h2;
    localparam logic [1:0] BW_6MHZ = 2'h0;
    localparam logic [1:0] BW_7MHZ = 2'h1;
    localparam logic [1:0] BW_8MHZ = 2'h2;
    localparam logic [1:0] KIND_DATA   = 2'h0;
    localparam logic [1:0] KIND_PARITY = 2'h1;
    localparam logic [1:0] KIND_GAP    = 2'h2;
    // ========================================
    // reset values
    localparam logic [2:0]  RST_OUT_EN  = 3'h0;
    localparam logic [1:0]  RST_TS_CFG  = 2'h0;
    localparam logic [7:0]  RST_GAIN_LVL = 8'h00;
    localparam logic [15:0] RST_XTAL_KHZ = 16'hEE48;
    localparam logic [15:0] RST_IF_KHZ   = 16'h8D1D;
    localparam logic [1:0]  RST_BW       = BW_8MHZ;
    localparam int PWM_BITS = 8;
endpackage

// file: dopc_sync.sv
// two flip-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module dopc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         srst,
    // level in and out
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_r;
    // ========================================
    // first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (srst) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

// file: dopc_pwm.sv
// pulse width modulator for one gain control output
`timescale 1ns/1ns
`default_nettype none
module dopc_pwm
    import dopc_pkg::*;
#(
    parameter int BITS = dopc_pkg::PWM_BITS
) (
    // clock and reset
    input  wire logic            core_clk,
    input  wire logic            srst,
    // duty level, all ones is maximum
    input  wire logic [BITS-1:0] level,
    // modulated output
    output logic                 pwm_out
);
    logic [BITS-1:0] cnt_r;
    initial begin
        if (BITS < 2 || BITS > 16) $error("dopc_pwm: BITS out of range");
    end
    // ========================================
    // free running period counter
    always_ff @(posedge core_clk) begin
        if (srst) cnt_r <= '0;
        else cnt_r <= cnt_r + 1'b1;
    end
    // all ones stays high for the whole period, all zeros never
    always_ff @(posedge core_clk) begin
        if (srst) pwm_out <= 1'b0;
        else pwm_out <= (level == '1) || (cnt_r < level);
    end
endmodule
`default_nettype wire

// file: dopc_top.sv
// output pin configuration: driver enables, lock pins, stream gating, gain
//
// Notes on behaviour
// - after reset every output pin is high impedance
// - stream driver enable false tristates stream pins, true drives them
// - professional variant only: monitor enable drives monitor pins, default tristate
// - one misc enable drives both lock pins, bus enable, interrupt, bus clock
// - host reads back the driver state of stream, monitor and misc groups
// - parity option puts parity bytes on the data lines between packets
// - gap clock gate stops the byte clock during all non valid bytes
// - continuous clock: valid low on non valid bytes, decoder discards them
// - indicator mode: pins show demodulator lock and correction lock
// - filter8 mode: pin high for 8 MHz, low for 7 or 6 MHz
// - filter7 mode: pin high for 7 or 8 MHz, low for 6 MHz
// - fixed modes hold the pin low or high
// - gain mode off, fast hardwired loop, or slow processor loop per symbol
// - positive gain by default, negative only with the slow loop
// - each gain output drives its default level when no loop acts
// - channel parameters are held until the start command
// - timing recovery locks within 500 ppm of programmed clock
// - device is a serial bus slave with two byte register address
// - gain outputs are pwm trains with 256 levels, all ones maximum
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module dopc_top #(
    parameter bit PRO_VARIANT = 1'b1,
    parameter int MON_W       = 8
) (
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     srst,
    // register port
    input  wire logic [dopc_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [dopc_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [dopc_pkg::DATA_W-1:0] reg_rdata,
    // demodulator core status
    input  wire logic                     demod_locked,
    input  wire logic                     corr_locked,
    input  wire logic [1:0]               detected_bw,
    input  wire logic [7:0]               fast_gain,
    input  wire logic [7:0]               proc_gain,
    input  wire logic [MON_W-1:0]         monitor_data,
    input  wire logic                     sec_bus_en_in,
    input  wire logic                     irq_in,
    input  wire logic                     sec_bus_clk_in,
    // stream source from the correction stage
    input  wire logic                     byte_clk_in,
    input  wire logic [7:0]               src_byte,
    input  wire logic [1:0]               src_kind,
    output logic                          src_take,
    // stream pins
    output logic [7:0]                    stream_data,
    output logic                          stream_clk,
    output logic                          stream_valid,
    output logic                          stream_oe,
    // monitor pins
    output logic [MON_W-1:0]              monitor_pins,
    output logic                          monitor_oe,
    // misc pins
    output logic                          demod_lock_pin,
    output logic                          correction_lock_pin,
    output logic                          secondary_bus_enable_pin,
    output logic                          interrupt_request_pin,
    output logic                          secondary_bus_clock_pin,
    output logic                          misc_oe,
    // gain pins
    output logic [2:0]                    gain_pwm,
    output logic                          gain_oe,
    // committed parameters towards the demodulator
    output logic [15:0]                   act_xtal_khz,
    output logic [15:0]                   act_if_khz,
    output logic                          act_mirror,
    output logic [1:0]                    act_bw,
    output logic                          proc_start
);
    import dopc_pkg::*;

    initial begin
        if (MON_W < 1 || MON_W > DATA_W) $error("dopc_top: MON_W out of range");
    end

    // ========================================
    // helpers
    function automatic logic lock_level(input logic [2:0] mode, input logic ind,
                                        input logic [1:0] bw);
        unique case (mode)
            LOCK_PIN_INDICATOR_SEL: lock_level = ind;
            LOCK_PIN_FILTER8_SEL:   lock_level = (bw == BW_8MHZ);
            LOCK_PIN_FILTER7_SEL:   lock_level = (bw != BW_6MHZ);
            LOCK_PIN_FIXED_HIGH:    lock_level = 1'b1;
            default:                lock_level = 1'b0;
        endcase
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // ========================================
    // configuration storage
    logic [2:0]  out_en_r;
    logic [1:0]  ts_cfg_r;
    logic [2:0]  demod_mode_r;
    logic [2:0]  corr_mode_r;
    logic [1:0]  gain_mode_r;
    logic        gain_neg_r;
    logic [7:0]  lvl_r [3];
    logic [15:0] xtal_r;
    logic [15:0] if_r;
    logic        mirror_r;
    logic [1:0]  bw_r;
    logic        started_r;
    logic        wr_start;

    assign wr_start = reg_wr && hit(reg_addr, OFS_START);

    // driver enables, monitor bit only exists on the professional part
    always_ff @(posedge core_clk) begin
        if (srst) begin
            out_en_r <= RST_OUT_EN;
        end else if (reg_wr && hit(reg_addr, OFS_OUT_EN)) begin
            out_en_r[BIT_STREAM_EN]  <= reg_wdata[BIT_STREAM_EN];
            out_en_r[BIT_MONITOR_EN] <= PRO_VARIANT & reg_wdata[BIT_MONITOR_EN];
            out_en_r[BIT_MISC_EN]    <= reg_wdata[BIT_MISC_EN];
        end
    end

    // stream options and lock pin functions
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ts_cfg_r     <= RST_TS_CFG;
            demod_mode_r <= LOCK_PIN_INDICATOR_SEL;
            corr_mode_r  <= LOCK_PIN_INDICATOR_SEL;
        end else begin
            if (reg_wr && hit(reg_addr, OFS_TS_CFG))
                ts_cfg_r <= reg_wdata[1:0];
            if (reg_wr && hit(reg_addr, OFS_LOCK_MODE)) begin
                demod_mode_r <= reg_wdata[POS_DEMOD_MODE +: 3];
                corr_mode_r  <= reg_wdata[POS_CORR_MODE +: 3];
            end
        end
    end

    // gain settings; negative sense is kept but only honoured in slow mode
    always_ff @(posedge core_clk) begin
        if (srst) begin
            gain_mode_r <= GAIN_OFF;
            gain_neg_r  <= 1'b0;
            lvl_r[0]    <= RST_GAIN_LVL;
            lvl_r[1]    <= RST_GAIN_LVL;
            lvl_r[2]    <= RST_GAIN_LVL;
        end else if (reg_wr) begin
            if (hit(reg_addr, OFS_GAIN_CTRL)) begin
                gain_mode_r <= reg_wdata[POS_GAIN_MODE +: 2];
                gain_neg_r  <= reg_wdata[BIT_GAIN_NEG];
            end
            if (hit(reg_addr, OFS_GAIN_LVL1)) lvl_r[0] <= reg_wdata[7:0];
            if (hit(reg_addr, OFS_GAIN_LVL2)) lvl_r[1] <= reg_wdata[7:0];
            if (hit(reg_addr, OFS_GAIN_LVL3)) lvl_r[2] <= reg_wdata[7:0];
        end
    end

    // staged channel parameters, invisible to the core until start
    always_ff @(posedge core_clk) begin
        if (srst) begin
            xtal_r   <= RST_XTAL_KHZ;
            if_r     <= RST_IF_KHZ;
            mirror_r <= 1'b0;
            bw_r     <= RST_BW;
        end else if (reg_wr) begin
            if (hit(reg_addr, OFS_XTAL_KHZ)) xtal_r <= reg_wdata;
            if (hit(reg_addr, OFS_IF_KHZ))   if_r   <= reg_wdata;
            if (hit(reg_addr, OFS_CHAN)) begin
                mirror_r <= reg_wdata[BIT_MIRROR];
                bw_r     <= reg_wdata[POS_BW +: 2];
            end
        end
    end

    // commit on start; a one cycle pulse tells the processor to run
    always_ff @(posedge core_clk) begin
        if (srst) begin
            act_xtal_khz <= RST_XTAL_KHZ;
            act_if_khz   <= RST_IF_KHZ;
            act_mirror   <= 1'b0;
            act_bw       <= RST_BW;
            proc_start   <= 1'b0;
            started_r    <= 1'b0;
        end else begin
            proc_start <= wr_start;
            if (wr_start) begin
                act_xtal_khz <= xtal_r;
                act_if_khz   <= if_r;
                act_mirror   <= mirror_r;
                act_bw       <= bw_r;
                started_r    <= 1'b1;
            end
        end
    end

    // ========================================
    // read port, unmapped offsets read zero; the serial slave sits in front of it
    always_ff @(posedge core_clk) begin
        if (srst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= '0;
            unique case (reg_addr)
                OFS_OUT_EN:    reg_rdata[2:0] <= {misc_oe, monitor_oe, stream_oe};
                OFS_TS_CFG:    reg_rdata[1:0] <= ts_cfg_r;
                OFS_LOCK_MODE: reg_rdata <= {9'h000, corr_mode_r, 1'b0, demod_mode_r};
                OFS_GAIN_CTRL: reg_rdata[2:0] <= {gain_neg_r, gain_mode_r};
                OFS_GAIN_LVL1: reg_rdata[7:0] <= lvl_r[0];
                OFS_GAIN_LVL2: reg_rdata[7:0] <= lvl_r[1];
                OFS_GAIN_LVL3: reg_rdata[7:0] <= lvl_r[2];
                OFS_XTAL_KHZ:  reg_rdata <= xtal_r;
                OFS_IF_KHZ:    reg_rdata <= if_r;
                OFS_CHAN:      reg_rdata[3:0] <= {bw_r, 1'b0, mirror_r};
                OFS_STATUS:    reg_rdata[4:0] <= {started_r, detected_bw, corr_locked, demod_locked};
                default:       reg_rdata <= '0;
            endcase
        end
    end

    // ========================================
    // pin drivers; enables come straight from storage so a write shows next cycle
    assign stream_oe  = out_en_r[BIT_STREAM_EN];
    assign monitor_oe = out_en_r[BIT_MONITOR_EN];
    assign misc_oe    = out_en_r[BIT_MISC_EN];
    assign gain_oe    = out_en_r[BIT_MISC_EN];

    // lock pins and pass-through misc pins, registered once
    always_ff @(posedge core_clk) begin
        if (srst) begin
            demod_lock_pin           <= 1'b0;
            correction_lock_pin      <= 1'b0;
            secondary_bus_enable_pin <= 1'b0;
            interrupt_request_pin    <= 1'b1;
            secondary_bus_clock_pin  <= 1'b1;
            monitor_pins             <= '0;
        end else begin
            demod_lock_pin      <= lock_level(demod_mode_r, demod_locked, detected_bw);
            correction_lock_pin <= lock_level(corr_mode_r, corr_locked, detected_bw);
            secondary_bus_enable_pin <= sec_bus_en_in;
            interrupt_request_pin    <= irq_in;
            secondary_bus_clock_pin  <= sec_bus_clk_in;
            monitor_pins             <= monitor_data;
        end
    end

    // ========================================
    // gain control selection for the first output; others use defaults
    logic [7:0] gain1_nxt;
    always_comb begin
        unique case (gain_mode_r)
            GAIN_FAST: gain1_nxt = fast_gain;
            GAIN_SLOW: gain1_nxt = gain_neg_r ? ~proc_gain : proc_gain;
            default:   gain1_nxt = lvl_r[0];
        endcase
    end

    dopc_pwm #(.BITS(PWM_BITS)) u_pwm1 (
        .core_clk (core_clk),
        .srst     (srst),
        .level    (gain1_nxt),
        .pwm_out  (gain_pwm[0])
    );
    dopc_pwm #(.BITS(PWM_BITS)) u_pwm2 (
        .core_clk (core_clk),
        .srst     (srst),
        .level    (lvl_r[1]),
        .pwm_out  (gain_pwm[1])
    );
    dopc_pwm #(.BITS(PWM_BITS)) u_pwm3 (
        .core_clk (core_clk),
        .srst     (srst),
        .level    (lvl_r[2]),
        .pwm_out  (gain_pwm[2])
    );

    // ========================================
    // stream output, byte clock sampled from the link
    logic bclk_s;
    logic bclk_d_r;
    logic rise;
    logic gated_r;

    dopc_sync #(.W(1)) u_bclk_sync (
        .core_clk (core_clk),
        .srst     (srst),
        .async_in (byte_clk_in),
        .sync_out (bclk_s)
    );

    assign rise = bclk_s && !bclk_d_r;

    always_ff @(posedge core_clk) begin
        if (srst) bclk_d_r <= 1'b0;
        else bclk_d_r <= bclk_s;
    end

    // one byte per link clock rise; data change while the clock is low
    always_ff @(posedge core_clk) begin
        if (srst) begin
            stream_data  <= 8'h00;
            stream_valid <= 1'b0;
            src_take     <= 1'b0;
            gated_r      <= 1'b0;
        end else begin
            src_take <= rise;
            if (rise) begin
                stream_valid <= (src_kind == KIND_DATA);
                gated_r      <= ts_cfg_r[BIT_GAP_GATE] && (src_kind != KIND_DATA);
                if (src_kind == KIND_DATA)
                    stream_data <= src_byte;
                else if (src_kind == KIND_PARITY && ts_cfg_r[BIT_PARITY])
                    stream_data <= src_byte;
                else
                    stream_data <= 8'h00;
            end
        end
    end

    // clock follows the link, held low for gated bytes
    always_ff @(posedge core_clk) begin
        if (srst) stream_clk <= 1'b0;
        else stream_clk <= bclk_d_r && !gated_r && !rise;
    end

    // ========================================
    // checks
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    property p_reset_hiz;
        $fell(srst) |-> !stream_oe && !monitor_oe && !misc_oe && !gain_oe;
    endproperty
    a_reset_hiz: assert property (p_reset_hiz) else $error("pins driven after reset");

    property p_stream_en;
        reg_wr && reg_addr == OFS_OUT_EN |=> stream_oe == $past(reg_wdata[BIT_STREAM_EN]);
    endproperty
    a_stream_en: assert property (p_stream_en) else $error("stream enable not applied");

    property p_mon_pro;
        !PRO_VARIANT |-> !monitor_oe;
    endproperty
    a_mon_pro: assert property (p_mon_pro) else $error("monitor driven on basic part");

    property p_readback;
        reg_rd && reg_addr == OFS_OUT_EN |=> reg_rdata[2:0] == $past({misc_oe, monitor_oe, stream_oe});
    endproperty
    a_readback: assert property (p_readback) else $error("enable readback wrong");

    property p_fixed_high;
        demod_mode_r == LOCK_PIN_FIXED_HIGH ##1 demod_mode_r == LOCK_PIN_FIXED_HIGH |-> demod_lock_pin;
    endproperty
    a_fixed_high: assert property (p_fixed_high) else $error("fixed high not held");

    property p_filter8;
        corr_mode_r == LOCK_PIN_FILTER8_SEL |=> correction_lock_pin == ($past(detected_bw) == BW_8MHZ);
    endproperty
    a_filter8: assert property (p_filter8) else $error("filter8 level wrong");

    property p_hold;
        !wr_start |=> $stable(act_bw) && $stable(act_xtal_khz);
    endproperty
    a_hold: assert property (p_hold) else $error("parameters changed without start");

    property p_gate;
        gated_r |-> !stream_clk;
    endproperty
    a_gate: assert property (p_gate) else $error("clock toggles in gated byte");

    property p_slow_neg;
        gain_mode_r == GAIN_SLOW && gain_neg_r |-> gain1_nxt == ~proc_gain;
    endproperty
    a_slow_neg: assert property (p_slow_neg) else $error("negative slow gain wrong");
endmodule
`default_nettype wire

// file: dopc_src_model.sv
// link source model: byte clock runs only within frames
`timescale 1ns/1ns
`default_nettype none
module dopc_src_model
    import dopc_pkg::*;
(
    // frame request
    input  wire logic run,
    // link towards the block
    output logic      link_clk,
    output logic [7:0] link_byte,
    output logic [1:0] link_kind
);
    int n = 0;
    // ========================================
    // 80 ns period; a started period ends low so the clock rests
    initial link_clk = 1'b0;
    always #40 begin
        if (run || link_clk) begin
            link_clk = ~link_clk;
        end
    end
    // next byte after each fall, clear of the sampled rise
    always @(negedge link_clk) begin
        n <= n + 1;
    end
    // two data bytes, one parity byte, one gap byte
    assign link_byte = n[7:0];
    assign link_kind = (n[1:0] == 2'h2) ? KIND_PARITY : (n[1:0] == 2'h3) ? KIND_GAP : KIND_DATA;
endmodule
`default_nettype wire

// file: testbench.sv
// self-checking bench for the output pin configuration block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import dopc_pkg::*;
    // ========================================
    // design signals
    logic core_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, demod_locked = 1, corr_locked = 0, frame = 0;
    logic [7:0] reg_addr = 0, fast_gain = 0, proc_gain = 0, monitor_data = 8'hA5, src_byte, stream_data;
    logic [15:0] reg_wdata = 0, reg_rdata, act_xtal_khz, act_if_khz, rv;
    logic [1:0] detected_bw = 0, src_kind, act_bw, ts = 0;
    logic byte_clk_in, src_take, stream_clk, stream_valid, stream_oe, monitor_oe, misc_oe, gain_oe;
    logic demod_lock_pin, correction_lock_pin, secondary_bus_enable_pin, interrupt_request_pin;
    logic secondary_bus_clock_pin, act_mirror, proc_start;
    logic [7:0] monitor_pins;
    logic [2:0] gain_pwm;
    int failures = 0, checks = 0, cyc = 0, k = 0, tog = 0;
    always #5 core_clk = ~core_clk;
    dopc_top DUT(.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .demod_locked,
        .corr_locked, .detected_bw, .fast_gain, .proc_gain, .monitor_data, .sec_bus_en_in(1'b0),
        .irq_in(1'b1), .sec_bus_clk_in(1'b0), .byte_clk_in, .src_byte, .src_kind, .src_take,
        .stream_data, .stream_clk, .stream_valid, .stream_oe, .monitor_pins, .monitor_oe,
        .demod_lock_pin, .correction_lock_pin, .secondary_bus_enable_pin, .interrupt_request_pin,
        .secondary_bus_clock_pin, .misc_oe, .gain_pwm, .gain_oe, .act_xtal_khz, .act_if_khz,
        .act_mirror, .act_bw, .proc_start);
    dopc_src_model SRC(.run(frame), .link_clk(byte_clk_in), .link_byte(src_byte), .link_kind(src_kind));
    // ========================================
    // register port: one strobe cycle, never held over
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // read data appears in the cycle after the strobe and holds until the next read
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ones on one gain train over a 256 step period, after settling
    task automatic ones(input int ch, output int c);
        c = 0;
        repeat (260) @(posedge core_clk);
        repeat (256) begin
            @(negedge core_clk);
            c += gain_pwm[ch];
        end
    endtask
    function automatic logic lp(input logic [2:0] m, input logic [1:0] b, input logic l);
        case (m)
            3'h0: lp = l;
            3'h1: lp = (b == BW_8MHZ);
            3'h2: lp = (b != BW_6MHZ);
            3'h4: lp = 1'b1;
            default: lp = 1'b0;
        endcase
    endfunction
    // stream watcher; valid checked on every byte, data on all but gap bytes, clock watched on non valid bytes
    always @(negedge core_clk) begin
        if (src_take === 1'b1) begin
            chk("valid", {15'h0, k[1] == 1'b0}, {15'h0, stream_valid});
            if (k[1:0] != 2'h3) begin
                chk("data", (k[1] && !ts[0]) ? 16'h0 : {8'h0, k[7:0]}, {8'h0, stream_data});
            end
            k++;
        end
        if (stream_valid === 1'b0 && stream_clk === 1'b1) begin
            tog++;
        end
    end
    // hang guard, well above the run length
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 8000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        int n;
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        @(negedge core_clk);
        chk("oe", 16'h0, {12'h0, stream_oe, monitor_oe, misc_oe, gain_oe});
        rd(OFS_OUT_EN, rv);
        chk("out_en", {13'h0, RST_OUT_EN}, rv);
        rd(8'hFF, rv);
        chk("unmapped", 16'h0, rv);
        wr(OFS_OUT_EN, 16'h0007);
        @(negedge core_clk);
        chk("oe_on", 16'h000F, {12'h0, stream_oe, monitor_oe, misc_oe, gain_oe});
        chk("mon", 16'h00A5, {8'h0, monitor_pins});
        chk("misc", 16'h0002, {13'h0, secondary_bus_enable_pin, interrupt_request_pin, secondary_bus_clock_pin});
        rd(OFS_OUT_EN, rv);
        chk("out_en", 16'h0007, rv);
        // every lock pin mode against every bandwidth
        for (int m = 0; m < 5; m++) begin
            for (int b = 0; b < 3; b++) begin
                detected_bw <= b[1:0];
                wr(OFS_LOCK_MODE, {9'h0, m[2:0], 1'b0, m[2:0]});
                repeat (2) @(posedge core_clk);
                @(negedge core_clk);
                chk("demod_pin", {15'h0, lp(m[2:0], b[1:0], 1'b1)}, {15'h0, demod_lock_pin});
                chk("corr_pin", {15'h0, lp(m[2:0], b[1:0], 1'b0)}, {15'h0, correction_lock_pin});
            end
        end
        wr(OFS_GAIN_CTRL, {13'h1, GAIN_SLOW});
        ones(0, n);
        chk("slow_neg", 16'h1, {15'h0, n >= 250});
        wr(OFS_GAIN_CTRL, {13'h1, GAIN_FAST});
        ones(0, n);
        chk("fast_neg", 16'h0, n[15:0]);
        wr(OFS_GAIN_LVL2, 16'h00FF);
        wr(OFS_GAIN_CTRL, {14'h0, GAIN_OFF});
        ones(0, n);
        chk("lvl1", 16'h0, n[15:0]);
        ones(1, n);
        chk("lvl2", 16'h1, {15'h0, n >= 250});
        ones(2, n);
        chk("lvl3", {8'h0, RST_GAIN_LVL}, n[15:0]);
        wr(OFS_XTAL_KHZ, 16'h1234);
        @(negedge core_clk);
        chk("held", RST_XTAL_KHZ, act_xtal_khz);
        wr(OFS_START, 16'h0001);
        @(negedge core_clk);
        chk("start", 16'h0001, {15'h0, proc_start});
        repeat (2) @(posedge core_clk);
        chk("commit", 16'h1234, act_xtal_khz);
        chk("commit_if", RST_IF_KHZ, act_if_khz);
        chk("commit_chan", {13'h0, RST_BW, 1'b0}, {13'h0, act_bw, act_mirror});
        rd(OFS_STATUS, rv);
        chk("status", 16'h0019, rv);
        // every stream option pair, one frame each
        for (int c = 0; c < 4; c++) begin
            wr(OFS_TS_CFG, c[15:0]);
            ts = c[1:0];
            tog = 0;
            frame <= 1'b1;
            for (int i = 0; i < 3000 && k < (c + 1) * 16; i++) begin
                @(posedge core_clk);
            end
            frame <= 1'b0;
            repeat (12) @(posedge core_clk);
            chk("gap_clk", {15'h0, !ts[1]}, {15'h0, tog > 0});
        end
        chk("bytes", 16'h1, {15'h0, k >= 64});
        conclude();
    end
endmodule
`default_nettype wire
